/* inc/spectral_threshold_pkg.sv */
// Constants for the spectral threshold interrupt block.
// Assumes byte-wide register accesses with 8-bit addresses.
package spectral_threshold_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] ADDR_PART_NUMBER = 8'h5A;
  localparam logic [7:0] ADDR_CHANNEL_SELECT = 8'h66;
  localparam logic [7:0] ADDR_LOW_LO = 8'h84;
  localparam logic [7:0] ADDR_LOW_HI = 8'h85;
  localparam logic [7:0] ADDR_HIGH_LO = 8'h86;
  localparam logic [7:0] ADDR_HIGH_HI = 8'h87;
  localparam logic [7:0] ADDR_STATUS3 = 8'h91;
  localparam logic [7:0] ADDR_STATUS = 8'h93;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int CHSEL_MSB = 2;
  localparam int FLAG_BIT = 3;
  localparam int ABOVE_BIT = 5;
  localparam int BELOW_BIT = 4;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [2:0] CHSEL_RESET = 3'h0;
  localparam logic [2:0] CHSEL_LAST = 3'h5;
  localparam int NUM_CHANNELS = 6;
  localparam int PERS_WIDTH = 4;
  localparam logic [PERS_WIDTH-1:0] PERS_ZERO = 4'h0;
  localparam logic [PERS_WIDTH-1:0] PERS_ONE = 4'h1;
  localparam logic [PERS_WIDTH-1:0] PERS_MAX = 4'hF;

  // Arbitrary neutral identification value
  localparam logic [7:0] PART_NUMBER_DEFAULT = 8'h3C;

endpackage

/* design/spectral_threshold_interrupt.sv */
// Window comparator with persistence and a sticky spectral interrupt flag.
// Assumes a byte register port synchronous to clock, and six channel
// result words that are stable while result_valid pulses.
// ----------------------------------------
// Notes on behaviour
// ----------------------------------------
// Notes on behaviour
// - Low and high 16-bit thresholds are compared with the selected channel's result after every measurement while channel select holds 0 to 5.
// - With the enable set, enough consecutive out-of-range measurements raise the spectral interrupt.
// - A result strictly below the low threshold counts as out of range.
// - A result strictly above the high threshold counts as out of range.
// - The low threshold takes bits 7:0 from offset 0x84 and bits 15:8 from 0x85.
// - The high threshold takes bits 7:0 from offset 0x86 and bits 15:8 from 0x87.
// - A write to the low threshold's low byte only fills an 8-bit holding latch.
// - Writing the low threshold's high byte applies both bytes to the comparator at once.
// - Bits 2:0 of the channel select register pick channel 0 to 5, resetting to 0.
// - The interrupt event sets status bit 3, which the host clears by writing 1.
// - Separate read-only bits tell whether the interrupt came from above high or below low.
`timescale 1ns/1ps

module spectral_threshold_interrupt
  import spectral_threshold_pkg::*;
#(
  parameter logic [7:0] PART_NUMBER = PART_NUMBER_DEFAULT
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Measurement results
  input wire logic result_valid,
  input wire logic [15:0] channel_zero_result,
  input wire logic [15:0] channel_one_result,
  input wire logic [15:0] channel_two_result,
  input wire logic [15:0] channel_three_result,
  input wire logic [15:0] channel_four_result,
  input wire logic [15:0] channel_five_result,
  // Control levels kept outside this block
  input wire logic spectral_irq_enable,
  input wire logic [PERS_WIDTH-1:0] persistence_count,
  // Status out
  output logic spectral_irq_flag,
  output logic above_high_indication,
  output logic below_low_indication
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [15:0] pick_channel(input logic [2:0] sel, input logic [15:0] c0,
    input logic [15:0] c1, input logic [15:0] c2, input logic [15:0] c3,
    input logic [15:0] c4, input logic [15:0] c5);
    logic [15:0] v;
    v = c0;
    case (sel)
      3'h0: v = c0;
      3'h1: v = c1;
      3'h2: v = c2;
      3'h3: v = c3;
      3'h4: v = c4;
      3'h5: v = c5;
      default: v = c0;
    endcase
    return v;
  endfunction

  function automatic logic is_write(input logic wr, input logic [7:0] addr, input logic [7:0] target);
    return wr && (addr == target);
  endfunction

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  logic [2:0] chsel_r;
  logic [7:0] low_latch_r;
  logic [15:0] low_thr_r;
  logic [15:0] high_thr_r;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      chsel_r <= CHSEL_RESET;
    else if (is_write(reg_wr, reg_addr, ADDR_CHANNEL_SELECT))
      chsel_r <= reg_wdata[CHSEL_MSB:0];
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      low_latch_r <= BYTE_RESET;
      low_thr_r <= WORD_RESET;
    end
    else
    begin
      if (is_write(reg_wr, reg_addr, ADDR_LOW_LO))
        low_latch_r <= reg_wdata;
      if (is_write(reg_wr, reg_addr, ADDR_LOW_HI))
        low_thr_r <= {reg_wdata, low_latch_r};
    end
  end

  // No holding latch here, so a two-byte update passes a mixed value briefly
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      high_thr_r <= WORD_RESET;
    else if (is_write(reg_wr, reg_addr, ADDR_HIGH_LO))
      high_thr_r[7:0] <= reg_wdata;
    else if (is_write(reg_wr, reg_addr, ADDR_HIGH_HI))
      high_thr_r[15:8] <= reg_wdata;
  end

  // ----------------------------------------
  // Comparison and persistence
  // ----------------------------------------
  logic [15:0] sel_result;
  logic chsel_ok;
  logic is_below;
  logic is_above;
  logic out_of_range;
  logic [PERS_WIDTH-1:0] pers_r;
  logic [PERS_WIDTH-1:0] pers_nxt;
  logic [PERS_WIDTH-1:0] pers_goal;
  logic irq_event;

  assign sel_result = pick_channel(chsel_r, channel_zero_result, channel_one_result,
    channel_two_result, channel_three_result, channel_four_result, channel_five_result);
  // Codes 6 and 7 select nothing and never count
  assign chsel_ok = (chsel_r <= CHSEL_LAST);
  assign is_below = chsel_ok && (sel_result < low_thr_r);
  assign is_above = chsel_ok && (sel_result > high_thr_r);
  assign out_of_range = is_below || is_above;
  // A setting of zero behaves as one
  assign pers_goal = (persistence_count == PERS_ZERO) ? PERS_ONE : persistence_count;

  always_comb
  begin
    pers_nxt = pers_r;
    if (result_valid)
    begin
      if (!out_of_range)
        pers_nxt = PERS_ZERO;
      else if (pers_r != PERS_MAX)
        pers_nxt = pers_r + PERS_ONE;
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      pers_r <= PERS_ZERO;
    else
      pers_r <= pers_nxt;
  end

  assign irq_event = result_valid && out_of_range && spectral_irq_enable && (pers_nxt >= pers_goal);

  // ----------------------------------------
  // Status flags
  // ----------------------------------------
  logic flag_r;
  logic above_r;
  logic below_r;
  logic flag_clear;

  assign flag_clear = is_write(reg_wr, reg_addr, ADDR_STATUS) && reg_wdata[FLAG_BIT];

  // A new event in the clearing cycle keeps the flag set
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      flag_r <= 1'b0;
    else if (irq_event)
      flag_r <= 1'b1;
    else if (flag_clear)
      flag_r <= 1'b0;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      above_r <= 1'b0;
      below_r <= 1'b0;
    end
    else if (irq_event)
    begin
      above_r <= is_above;
      below_r <= is_below;
    end
  end

  assign spectral_irq_flag = flag_r;
  assign above_high_indication = above_r;
  assign below_low_indication = below_r;

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;

  always_comb
  begin
    rdata_nxt = BYTE_RESET;
    case (reg_addr)
      ADDR_PART_NUMBER: rdata_nxt = PART_NUMBER;
      ADDR_CHANNEL_SELECT: rdata_nxt = {5'h00, chsel_r};
      ADDR_LOW_LO: rdata_nxt = low_latch_r;
      ADDR_LOW_HI: rdata_nxt = low_thr_r[15:8];
      ADDR_HIGH_LO: rdata_nxt = high_thr_r[7:0];
      ADDR_HIGH_HI: rdata_nxt = high_thr_r[15:8];
      ADDR_STATUS3: rdata_nxt = {2'h0, above_r, below_r, 4'h0};
      ADDR_STATUS: rdata_nxt = {4'h0, flag_r, 3'h0};
      default: rdata_nxt = BYTE_RESET;
    endcase
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      rdata_r <= BYTE_RESET;
    else if (reg_rd)
      rdata_r <= rdata_nxt;
  end

  assign reg_rdata = rdata_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_low_latch_hold: assert property (@(posedge clock) disable iff (rst)
    (reg_wr && reg_addr == ADDR_LOW_LO) |=> $stable(low_thr_r))
    else $error("low byte write changed the low threshold");

  a_low_pair_apply: assert property (@(posedge clock) disable iff (rst)
    (reg_wr && reg_addr == ADDR_LOW_HI) |=> (low_thr_r == {$past(reg_wdata), $past(low_latch_r)}))
    else $error("low threshold not applied as a pair");

  a_low_only_msb: assert property (@(posedge clock) disable iff (rst)
    !(reg_wr && reg_addr == ADDR_LOW_HI) |=> $stable(low_thr_r))
    else $error("low threshold changed without high byte write");

  a_high_direct: assert property (@(posedge clock) disable iff (rst)
    (reg_wr && reg_addr == ADDR_HIGH_LO) |=> (high_thr_r[7:0] == $past(reg_wdata)))
    else $error("high threshold low byte not applied");

  a_high_msb_direct: assert property (@(posedge clock) disable iff (rst)
    (reg_wr && reg_addr == ADDR_HIGH_HI) |=> (high_thr_r[15:8] == $past(reg_wdata)))
    else $error("high threshold high byte not applied");

  a_chsel_write: assert property (@(posedge clock) disable iff (rst)
    (reg_wr && reg_addr == ADDR_CHANNEL_SELECT) |=> (chsel_r == $past(reg_wdata[2:0])))
    else $error("channel select not stored");

  a_window_reset: assert property (@(posedge clock) disable iff (rst)
    (result_valid && chsel_r <= CHSEL_LAST && sel_result >= low_thr_r && sel_result <= high_thr_r)
    |=> (pers_r == PERS_ZERO))
    else $error("in-window result did not reset the counter");

  a_below_counts: assert property (@(posedge clock) disable iff (rst)
    (result_valid && chsel_r <= CHSEL_LAST && sel_result < low_thr_r && pers_r != PERS_MAX)
    |=> (pers_r == $past(pers_r) + PERS_ONE))
    else $error("below-low result did not count");

  a_above_counts: assert property (@(posedge clock) disable iff (rst)
    (result_valid && chsel_r <= CHSEL_LAST && sel_result > high_thr_r && pers_r != PERS_MAX)
    |=> (pers_r == $past(pers_r) + PERS_ONE))
    else $error("above-high result did not count");

  a_irq_raise: assert property (@(posedge clock) disable iff (rst)
    (irq_event) |=> spectral_irq_flag)
    else $error("interrupt not raised after persistence met");

  a_irq_needs_enable: assert property (@(posedge clock) disable iff (rst)
    (!spectral_irq_flag && !spectral_irq_enable) |=> !spectral_irq_flag)
    else $error("interrupt raised while disabled");

  a_flag_clear: assert property (@(posedge clock) disable iff (rst)
    (flag_clear && !irq_event) |=> !spectral_irq_flag)
    else $error("write of one did not clear the flag");

  a_flag_sticky: assert property (@(posedge clock) disable iff (rst)
    (spectral_irq_flag && !flag_clear) |=> spectral_irq_flag)
    else $error("flag dropped without clear");

  a_cause_bits: assert property (@(posedge clock) disable iff (rst)
    (irq_event) |=> (above_high_indication == $past(is_above) && below_low_indication == $past(is_below)))
    else $error("cause indication wrong");

  a_compare_value: assert property (@(posedge clock) disable iff (rst)
    (chsel_r == 3'h0) |-> (is_below == (channel_zero_result < low_thr_r)))
    else $error("comparison does not use the selected result");

endmodule

/* testbench/reg_host_model.sv */
// Host model: byte register accesses as an I2C host would issue them.
// Assumes the block takes one access per rising edge of clock.
`timescale 1ns/1ps

module reg_host_model
  import spectral_threshold_pkg::*;
(
  // Clock
  input wire logic clock,
  // Register port
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata
);
  initial
  begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end

  // Released address and data lines never keep their last value; both strobes drop to 0
  task automatic release_bus();
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    reg_addr <= ~reg_addr;
    reg_wdata <= ~reg_wdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    release_bus();
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    release_bus();
  endtask

  // Low byte first, high byte on the very next cycle, as one burst
  task automatic wr_low(input logic [15:0] v);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= ADDR_LOW_LO;
    reg_wdata <= v[7:0];
    @(posedge clock);
    reg_addr <= ADDR_LOW_HI;
    reg_wdata <= v[15:8];
    @(posedge clock);
    release_bus();
  endtask
endmodule

/* testbench/tb.sv */
// Self-checking bench for the spectral threshold interrupt block.
// Assumes the host model drives the register port; results come from here.
`timescale 1ns/1ps

module tb
  import spectral_threshold_pkg::*;
;
  `define CHK(a, e) begin compares++; if ((a) !== (e)) begin miscompares++; \
    $display("unexpected at %0t: got %h exp %h", $time, a, e); end end

  logic clock = 1'b0;
  logic rst = 1'b1;
  logic reg_wr, reg_rd, result_valid = 1'b0, spectral_irq_enable = 1'b1;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [15:0] ch [6] = '{default: 16'h0000};
  logic [PERS_WIDTH-1:0] persistence_count = 4'h1;
  logic spectral_irq_flag, above_high_indication, below_low_indication, rd_q = 1'b0;
  logic [7:0] expq [$];
  int miscompares = 0, compares = 0;
  logic [31:0] seed = 32'h00000025;
  // Popped once into a variable so a mismatch report does not pop a second note
  logic [7:0] exp_v;
  logic [2:0] pin_v;
  logic [2:0] pinq [$];
  logic rv_q = 1'b0;
  logic [7:0] map_addr [9] = '{ADDR_PART_NUMBER, ADDR_CHANNEL_SELECT, ADDR_LOW_LO, ADDR_LOW_HI, ADDR_HIGH_LO,
    ADDR_HIGH_HI, ADDR_STATUS, ADDR_STATUS3, 8'h00};
  logic [15:0] pers_seq [6] = '{16'hFFFF, 16'h0000, 16'h8000, 16'h0000, 16'hFFFF, 16'h0000};
  // Reference state of the block
  logic [15:0] lo = 16'h0000, hi = 16'h0000;
  logic [7:0] latch = 8'h00;
  logic [2:0] chsel = 3'h0;
  logic [3:0] cnt = 4'h0;
  logic flag = 1'b0, above = 1'b0, below = 1'b0;

  initial
  begin
    forever #12.5 clock = ~clock;
  end

  reg_host_model host (.clock(clock), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata));

  spectral_threshold_interrupt DUT (.clock(clock), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .result_valid(result_valid),
    .channel_zero_result(ch[0]), .channel_one_result(ch[1]), .channel_two_result(ch[2]),
    .channel_three_result(ch[3]), .channel_four_result(ch[4]), .channel_five_result(ch[5]),
    .spectral_irq_enable(spectral_irq_enable), .persistence_count(persistence_count),
    .spectral_irq_flag(spectral_irq_flag), .above_high_indication(above_high_indication),
    .below_low_indication(below_low_indication));

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [7:0] regv(input logic [7:0] a);
    case (a)
      ADDR_PART_NUMBER: return PART_NUMBER_DEFAULT;
      ADDR_CHANNEL_SELECT: return {5'h00, chsel};
      ADDR_LOW_LO: return latch;
      ADDR_LOW_HI: return lo[15:8];
      ADDR_HIGH_LO: return hi[7:0];
      ADDR_HIGH_HI: return hi[15:8];
      ADDR_STATUS: return {4'h0, flag, 3'h0};
      ADDR_STATUS3: return {2'h0, above, below, 4'h0};
      default: return 8'h00;
    endcase
  endfunction

  task automatic chk(input logic [7:0] a);
    expq.push_back(regv(a));
    host.rd(a);
  endtask

  task automatic w(input logic [7:0] a, input logic [7:0] d);
    host.wr(a, d);
    case (a)
      ADDR_LOW_LO: latch = d;
      ADDR_LOW_HI: lo = {d, latch};
      ADDR_HIGH_LO: hi[7:0] = d;
      ADDR_HIGH_HI: hi[15:8] = d;
      ADDR_CHANNEL_SELECT: chsel = d[2:0];
      ADDR_STATUS: flag = d[3] ? 1'b0 : flag;
      default: ;
    endcase
  endtask

  // Other channels get noise so a wrong channel pick shows up
  task automatic meas(input logic [15:0] v);
    logic out;
    @(posedge clock);
    for (int i = 0; i < 6; i++)
      ch[i] <= (i == chsel) ? v : 16'(xs());
    result_valid <= 1'b1;
    @(posedge clock);
    result_valid <= 1'b0;
    out = (chsel <= CHSEL_LAST) && (v < lo || v > hi);
    cnt = !out ? 4'h0 : (cnt == PERS_MAX) ? cnt : cnt + 4'h1;
    if (spectral_irq_enable && out && cnt >= ((persistence_count == 4'h0) ? 4'h1 : persistence_count))
    begin
      flag = 1'b1;
      above = v > hi;
      below = v < lo;
    end
    pinq.push_back({flag, above, below});
    chk(ADDR_STATUS);
    chk(ADDR_STATUS3);
  endtask

  task automatic summarize();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ----------------------------------------
  // Read result watcher
  // ----------------------------------------
  always @(posedge clock)
  begin
    rd_q <= reg_rd;
    rv_q <= result_valid;
    if (rd_q)
    begin
      exp_v = expq.pop_front();
      `CHK(reg_rdata, exp_v)
    end
    // Status pins settle one edge after the measurement is taken
    if (rv_q)
    begin
      pin_v = pinq.pop_front();
      `CHK({spectral_irq_flag, above_high_indication, below_low_indication}, pin_v)
    end
  end

  initial
  begin
    repeat (20000) @(posedge clock);
    miscompares++;
    summarize();
  end

  // ----------------------------------------
  // Stimulus
  // ----------------------------------------
  initial
  begin
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    foreach (map_addr[i])
      chk(map_addr[i]);
    w(ADDR_HIGH_LO, 8'hFF);
    w(ADDR_HIGH_HI, 8'hFF);
    w(ADDR_LOW_LO, 8'h34);
    chk(ADDR_LOW_LO);
    chk(ADDR_LOW_HI);
    meas(16'h0010);
    w(ADDR_LOW_HI, 8'h12);
    meas(16'h1234);
    meas(16'h1233);
    w(ADDR_STATUS, 8'hF7);
    chk(ADDR_STATUS);
    w(ADDR_STATUS, 8'h08);
    host.wr_low(16'hABCD);
    latch = 8'hCD;
    lo = 16'hABCD;
    chk(ADDR_LOW_HI);
    meas(16'hABCC);
    w(ADDR_STATUS, 8'h08);
    w(ADDR_LOW_HI, 8'h10);
    w(ADDR_HIGH_LO, 8'h00);
    meas(16'hFF00);
    meas(16'hFF01);
    w(ADDR_STATUS, 8'h08);
    persistence_count <= 4'h3;
    foreach (pers_seq[i])
      meas(pers_seq[i]);
    w(ADDR_STATUS, 8'h08);
    spectral_irq_enable <= 1'b0;
    repeat (3) meas(16'h0001);
    spectral_irq_enable <= 1'b1;
    meas(16'h0002);
    persistence_count <= 4'h0;
    for (int c = 0; c < 8; c++)
    begin
      w(ADDR_STATUS, 8'h08);
      w(ADDR_CHANNEL_SELECT, {5'(xs()), 3'(c)});
      chk(ADDR_CHANNEL_SELECT);
      meas(16'h0003);
    end
    repeat (40)
    begin
      if ((xs() & 32'h3) == 32'h0)
        w(ADDR_STATUS, 8'h08);
      w(ADDR_CHANNEL_SELECT, {5'h00, 3'(xs())});
      persistence_count <= 4'(xs() & 32'h3);
      spectral_irq_enable <= (xs() & 32'h7) != 32'h0;
      meas(16'(xs() >> (xs() & 32'hF)));
    end
    repeat (4) @(posedge clock);
    summarize();
  end
endmodule
